// ===== logic/uart_pin_pkg.sv
`default_nettype none
package uart_pin_pkg;
    localparam int          DATA_W         = 8;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          BUF_DEPTH      = 2;
    localparam int          FLOW_THRESHOLD = 14;
    localparam logic [7:0]  OFS_DATA       = 8'h00;
    localparam logic [7:0]  OFS_MODEM_CTRL = 8'h04;
    localparam logic [7:0]  OFS_MODEM_STAT = 8'h08;
    localparam logic [7:0]  OFS_FIFO_STAT  = 8'h0C;
    localparam logic [7:0]  OFS_DIVISOR    = 8'h10;
    localparam int          MC_TERM_READY  = 0;
    localparam int          MC_GO_AHEAD    = 1;
    localparam int          MC_USER_USER_OUTPUT_TWO   = 3;
    localparam int          MC_LOOPBACK    = 4;
    localparam int          MC_AUTO_FLOW   = 5;
    localparam int          MS_CALL_ALERT  = 6;
    localparam int          FS_TX_LSB      = 8;
    localparam int          FS_RX_FULL     = 16;
    localparam int          FS_TX_FULL     = 17;
    localparam int          FS_OVERRUN     = 18;
    localparam int          FS_FRAME_ERR   = 19;
    localparam logic [5:0]  MC_RESET       = 6'h00;
    localparam logic [15:0] DIV_RESET      = 16'h0001;
    localparam logic [3:0]  OS_LAST        = 4'hF;
    localparam logic [3:0]  OS_MID         = 4'h7;
    localparam logic [3:0]  TX_FRAME_BITS  = 4'hA;
    localparam logic [2:0]  RX_LAST_BIT    = 3'h7;
    localparam logic [2:0]  SYNC_RESET     = 3'h6;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_type;
endpackage : uart_pin_pkg
`default_nettype wire

// ===== logic/stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// ===== logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int             W         = 1,
    parameter logic [W-1:0]   RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ===== logic/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    rst_n,
    // Streams
    stream_if.snk        in_s,
    stream_if.src        out_s,
    // Fill level
    output var logic [CW-1:0] count
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || W < 1) begin : g_bad
            $error("stream_fifo needs DEPTH >= 2 and W >= 1");
        end
    endgenerate

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    wire           push = in_s.valid & in_s.ready;
    wire           pop  = out_s.valid & out_s.ready;

    assign in_s.ready  = (count != CW'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data  = mem[rd_ptr];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= bump(wr_ptr);
            if (pop) rd_ptr <= bump(rd_ptr);
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule : stream_fifo
`default_nettype wire

// ===== logic/uart_pin_channel.sv
`timescale 1ns/1ps
`default_nettype none
module uart_pin_channel #(
    parameter int DEPTH     = uart_pin_pkg::FIFO_DEPTH,
    parameter int THRESHOLD = uart_pin_pkg::FLOW_THRESHOLD
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Serial line
    input  wire logic        serial_in,
    output var  logic        serial_out,
    // Modem pins
    input  wire logic        call_alert_in_n,
    output var  logic        peer_go_ahead_out_n,
    output var  logic        terminal_ready_out_n,
    // Interrupt pin
    input  wire logic        interrupt_override_in,
    output var  logic        int_out,
    output var  logic        int_oe,
    // DMA flags
    output var  logic        rcv_fifo_dma_flag_n,
    output var  logic        xmit_fifo_dma_flag_n
);
    import uart_pin_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || THRESHOLD < 1 || THRESHOLD > DEPTH || CW > 8) begin : g_bad
            $error("uart_pin_channel: DEPTH or THRESHOLD out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pins_s;
    wire        serial_in_s = pins_s[2];
    wire        alert_s_n   = pins_s[1];
    wire        override_s  = pins_s[0];

    pin_sync #(
        .W         (3),
        .RESET_VAL (SYNC_RESET)
    ) u_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in ({serial_in, call_alert_in_n, interrupt_override_in}),
        .sync_out (pins_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Streams and FIFOs
    stream_if #(.W(DATA_W)) rx_raw ();
    stream_if #(.W(DATA_W)) rx_mid ();
    stream_if #(.W(DATA_W)) rx_q ();
    stream_if #(.W(DATA_W)) tx_in ();
    stream_if #(.W(DATA_W)) tx_q ();

    logic [1:0]    buf_count;
    logic [CW-1:0] rx_count;
    logic [CW-1:0] tx_count;

    // Small buffer absorbs a two-word stall from the receive FIFO
    stream_fifo #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
        .clk   (pclk),
        .rst_n (presetn),
        .in_s  (rx_raw),
        .out_s (rx_mid),
        .count (buf_count)
    );

    stream_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
        .clk   (pclk),
        .rst_n (presetn),
        .in_s  (rx_mid),
        .out_s (rx_q),
        .count (rx_count)
    );

    stream_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
        .clk   (pclk),
        .rst_n (presetn),
        .in_s  (tx_in),
        .out_s (tx_q),
        .count (tx_count)
    );

    wire rx_full  = (rx_count == CW'(DEPTH));
    wire tx_full  = (tx_count == CW'(DEPTH));
    wire rx_above = (rx_count >= CW'(THRESHOLD));

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [5:0]  modem_control_reg;
    logic [15:0] divisor;
    logic        overrun;
    logic        frame_err;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : is_reg

    wire hit_data  = is_reg(paddr, OFS_DATA);
    wire hit_ctrl  = is_reg(paddr, OFS_MODEM_CTRL);
    wire hit_stat  = is_reg(paddr, OFS_MODEM_STAT);
    wire hit_fifo  = is_reg(paddr, OFS_FIFO_STAT);
    wire hit_div   = is_reg(paddr, OFS_DIVISOR);
    wire mapped    = hit_data | hit_ctrl | hit_stat | hit_fifo | hit_div;
    wire setup     = psel & ~penable;
    wire done      = psel & penable & pready;
    wire wr_done   = done & pwrite & mapped;
    wire rd_done   = done & ~pwrite & mapped;
    wire loop_mode = modem_control_reg[MC_LOOPBACK];
    wire auto_flow = modem_control_reg[MC_AUTO_FLOW];

    // Logical not: a bitwise one would be widened first and fill the upper bits
    wire [31:0] stat_word = 32'(!alert_s_n) << MS_CALL_ALERT;
    wire [31:0] fifo_word = 32'(rx_count)
                          | (32'(tx_count) << FS_TX_LSB)
                          | (32'(rx_full) << FS_RX_FULL)
                          | (32'(tx_full) << FS_TX_FULL)
                          | (32'(overrun) << FS_OVERRUN)
                          | (32'(frame_err) << FS_FRAME_ERR);
    wire [31:0] data_word = rx_q.valid ? 32'(rx_q.data) : 32'h0000_0000;
    wire [31:0] next_prdata = hit_data ? data_word
                            : hit_ctrl ? 32'(modem_control_reg)
                            : hit_stat ? stat_word
                            : hit_fifo ? fifo_word
                            : hit_div  ? 32'(divisor)
                            : 32'h0000_0000;

    // A write to a full transmit FIFO is dropped; the DMA flag warns of it
    assign tx_in.valid = wr_done & hit_data;
    assign tx_in.data  = pwdata[DATA_W-1:0];
    assign rx_q.ready  = rd_done & hit_data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_control_reg <= MC_RESET;
            divisor           <= DIV_RESET;
        end else if (wr_done) begin
            if (hit_ctrl) modem_control_reg <= pwdata[5:0];
            if (hit_div) divisor <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oversampling tick (16 per bit)
    logic [15:0] div_cnt;
    wire         tick = (div_cnt <= 16'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= DIV_RESET;
        end else begin
            div_cnt <= tick ? divisor : div_cnt - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter: 8 data bits, no parity, one stop bit
    logic [3:0] tx_os;
    logic [3:0] tx_bits;
    logic [9:0] tx_shift;
    logic       tx_line;
    wire        tx_bit_end = tick & (tx_os == OS_LAST);

    assign tx_q.ready = (tx_bits == 4'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_os    <= 4'h0;
            tx_bits  <= 4'h0;
            tx_shift <= 10'h3FF;
            tx_line  <= 1'b1;
        end else begin
            if (tick) tx_os <= tx_os + 4'h1;
            if (tx_q.valid && tx_q.ready) begin
                tx_shift <= {1'b1, tx_q.data, 1'b0};
                tx_bits  <= TX_FRAME_BITS;
            end else if (tx_bit_end && tx_bits != 4'h0) begin
                tx_line  <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bits  <= tx_bits - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    rx_state_type rx_state;
    logic [3:0]   rx_os;
    logic [2:0]   rx_bits;
    logic [7:0]   rx_shift;
    logic         rx_push;
    wire          rx_line = loop_mode ? tx_line : serial_in_s;
    wire          rx_mid_pt = tick & (rx_os == OS_MID);
    wire          rx_bit_pt = tick & (rx_os == OS_LAST);

    assign rx_raw.valid = rx_push;
    assign rx_raw.data  = rx_shift;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            rx_os    <= 4'h0;
            rx_bits  <= 3'h0;
            rx_shift <= 8'h00;
            rx_push  <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            if (tick) rx_os <= rx_os + 4'h1;
            unique case (rx_state)
                RX_IDLE: begin
                    rx_os <= 4'h0;
                    if (!rx_line) rx_state <= RX_START;
                end
                RX_START: begin
                    if (rx_mid_pt) begin
                        rx_os    <= 4'h0;
                        rx_bits  <= 3'h0;
                        rx_state <= rx_line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_bit_pt) begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                        rx_bits  <= rx_bits + 3'h1;
                        if (rx_bits == RX_LAST_BIT) rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_bit_pt) begin
                        rx_push  <= rx_line;
                        rx_state <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Sticky errors: a new event beats the clearing read
    wire clr_err = rd_done & hit_fifo;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun   <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            overrun   <= (rx_push & ~rx_raw.ready) | (overrun & ~clr_err);
            frame_err <= (rx_state == RX_STOP && rx_bit_pt && !rx_line)
                       | (frame_err & ~clr_err);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pins
    wire next_go_ahead_n = ~(modem_control_reg[MC_GO_AHEAD]
                           & ~loop_mode
                           & ~(auto_flow & rx_above));
    wire next_serial_out = loop_mode | tx_line;
    wire next_int_oe     = override_s | modem_control_reg[MC_USER_USER_OUTPUT_TWO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peer_go_ahead_out_n  <= 1'b1;
            terminal_ready_out_n <= 1'b1;
            serial_out           <= 1'b1;
            int_out              <= 1'b0;
            int_oe               <= 1'b0;
            rcv_fifo_dma_flag_n  <= 1'b1;
            xmit_fifo_dma_flag_n <= 1'b1;
        end else begin
            peer_go_ahead_out_n  <= next_go_ahead_n;
            terminal_ready_out_n <= ~modem_control_reg[MC_TERM_READY];
            serial_out           <= next_serial_out;
            int_out              <= rx_q.valid;
            int_oe               <= next_int_oe;
            rcv_fifo_dma_flag_n  <= ~rx_full;
            xmit_fifo_dma_flag_n <= ~tx_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_alert_sync: assert property (
        ##2 alert_s_n == $past(call_alert_in_n, 2))
        else $error("call alert not two stages behind pin");
    chk_alert_read: assert property (
        setup && !pwrite && hit_stat |=> prdata[MS_CALL_ALERT] == $past(~alert_s_n))
        else $error("status bit 6 does not show call alert");
    chk_go_ahead_on: assert property (
        modem_control_reg[MC_GO_AHEAD] && !loop_mode && !auto_flow
        |=> !peer_go_ahead_out_n)
        else $error("go-ahead not driven active");
    chk_go_ahead_off: assert property (
        loop_mode || !modem_control_reg[MC_GO_AHEAD] |=> peer_go_ahead_out_n)
        else $error("go-ahead not forced inactive");
    chk_auto_flow: assert property (
        auto_flow && rx_count >= CW'(THRESHOLD) |=> peer_go_ahead_out_n)
        else $error("auto flow failed to drop go-ahead");
    chk_loop_feed: assert property (
        loop_mode |-> rx_line == tx_line ##1 serial_out)
        else $error("loopback path wrong");
    chk_rx_dma: assert property (
        ##1 rcv_fifo_dma_flag_n == !$past(rx_full))
        else $error("receive DMA flag wrong");
    chk_tx_dma: assert property (
        ##1 xmit_fifo_dma_flag_n == !$past(tx_full))
        else $error("transmit DMA flag wrong");
    chk_idle_mark: assert property (
        tx_bits == 4'h0 |=> serial_out)
        else $error("serial output left mark while idle");
    chk_terminal_pin: assert property (
        ##1 terminal_ready_out_n == !$past(modem_control_reg[MC_TERM_READY]))
        else $error("terminal ready does not follow bit 0");
    chk_int_enable: assert property (
        ##1 int_oe == $past(override_s | modem_control_reg[MC_USER_USER_OUTPUT_TWO]))
        else $error("interrupt enable wrong");

    cov_loop_frame: cover property (loop_mode && rx_push);
    cov_auto_drop: cover property (auto_flow && rx_above && $rose(peer_go_ahead_out_n));
    cov_tx_full: cover property ($fell(xmit_fifo_dma_flag_n));
    cov_overrun: cover property ($rose(overrun));
endmodule : uart_pin_channel
`default_nettype wire

// ===== test/modem_partner.sv
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
    // Clock
    input  wire logic pclk,
    // Line and ring pins
    output var  logic serial_in,
    output var  logic call_alert_in_n
);
    initial begin
        serial_in       = 1'b1;
        call_alert_in_n = 1'b1;
    end

    // One 8N1 frame, LSB first; line rests at mark after stop
    task automatic send(input logic [7:0] b, input int cpb);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_in <= f[i];
            repeat (cpb) @(posedge pclk);
        end
    endtask : send
endmodule : modem_partner
`default_nettype wire

// ===== test/uart_pin_channel_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_pin_channel_test;
    import uart_pin_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, ovr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, serial_in, serial_out, alert_n;
    logic        go_n, term_n, int_out, int_oe, rx_n, tx_n;
    int          error_cnt  = 0;
    int          num_checks = 0;

    uart_pin_channel #(.DEPTH(16), .THRESHOLD(14)) u_uart_pin_channel (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
        .serial_out(serial_out), .call_alert_in_n(alert_n),
        .peer_go_ahead_out_n(go_n), .terminal_ready_out_n(term_n),
        .interrupt_override_in(ovr), .int_out(int_out), .int_oe(int_oe),
        .rcv_fifo_dma_flag_n(rx_n), .xmit_fifo_dma_flag_n(tx_n));

    modem_partner u_modem_partner (
        .pclk(pclk), .serial_in(serial_in), .call_alert_in_n(alert_n));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic timeout;
        error_cnt++;
        tally_and_finish();
    endtask : timeout

    // Idle edge first, so psel never changes twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset

    task automatic wait_rx(input logic [4:0] cnt);
        int n;
        for (n = 0; n < 600; n++) begin
            apb(1'b0, OFS_FIFO_STAT, 32'h0);
            if (rd[4:0] === cnt) break;
        end
        if (n >= 600) timeout();
    endtask : wait_rx

    ////////////////////////////////////////
    task automatic t_reset;
        check({serial_out, go_n, term_n, int_oe, rx_n, tx_n}, 6'h3B);
        apb(1'b0, OFS_MODEM_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, OFS_DIVISOR, 32'h2);
        apb(1'b0, OFS_DIVISOR, 32'h0);
        check({err, rd[15:0]}, 17'h00002);
        apb(1'b1, OFS_DIVISOR, 32'h1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_pins;
        apb(1'b1, OFS_MODEM_CTRL, 32'h3);
        repeat (2) @(posedge pclk);
        check({go_n, term_n}, 2'h0);
        apb(1'b1, OFS_MODEM_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        check({go_n, term_n}, 2'h1);
        apb(1'b1, OFS_MODEM_CTRL, 32'h8);
        repeat (2) @(posedge pclk);
        check({go_n, int_oe}, 2'h3);
        apb(1'b1, OFS_MODEM_CTRL, 32'h0);
        ovr <= 1'b1;
        repeat (5) @(posedge pclk);
        check(int_oe, 1'b1);
        ovr <= 1'b0;
        repeat (5) @(posedge pclk);
        check(int_oe, 1'b0);
        apb(1'b1, OFS_MODEM_CTRL, 32'h12);
        repeat (2) @(posedge pclk);
        check(go_n, 1'b1);
        $display("pin test done");
    endtask : t_pins

    task automatic t_alert;
        u_modem_partner.call_alert_in_n <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_MODEM_STAT, 32'h0);
        check(rd[MS_CALL_ALERT], 1'b1);
        u_modem_partner.call_alert_in_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_MODEM_STAT, 32'h0);
        check(rd[MS_CALL_ALERT], 1'b0);
        $display("alert test done");
    endtask : t_alert

    // Pin held at break: any leak would corrupt the byte
    task automatic t_loop;
        apb(1'b1, OFS_MODEM_CTRL, 32'h10);
        u_modem_partner.serial_in <= 1'b0;
        apb(1'b1, OFS_DATA, 32'hA5);
        wait_rx(5'h01);
        check({serial_out, int_out}, 2'h3);
        apb(1'b0, OFS_DATA, 32'h0);
        check(rd[7:0], 8'hA5);
        u_modem_partner.serial_in <= 1'b1;
        do_reset();
        $display("loopback test done");
    endtask : t_loop

    task automatic t_flow;
        apb(1'b1, OFS_MODEM_CTRL, 32'h22);
        for (int i = 0; i < 13; i++) u_modem_partner.send(8'h30 + 8'(i), 16);
        wait_rx(5'h0D);
        check(go_n, 1'b0);
        u_modem_partner.send(8'h3D, 16);
        wait_rx(5'h0E);
        repeat (2) @(posedge pclk);
        check(go_n, 1'b1);
        u_modem_partner.send(8'h3E, 16);
        u_modem_partner.send(8'h3F, 16);
        wait_rx(5'h10);
        repeat (2) @(posedge pclk);
        check({rx_n, rd[FS_RX_FULL]}, 2'h1);
        apb(1'b0, OFS_DATA, 32'h0);
        check(rd[7:0], 8'h30);
        repeat (2) @(posedge pclk);
        check(rx_n, 1'b1);
        do_reset();
        $display("flow test done");
    endtask : t_flow

    task automatic t_txfill;
        int n;
        check(serial_out, 1'b1);
        for (n = 0; n < 20 && tx_n !== 1'b0; n++) apb(1'b1, OFS_DATA, 32'h5A);
        check(tx_n, 1'b0);
        apb(1'b0, OFS_FIFO_STAT, 32'h0);
        check(rd[FS_TX_FULL], 1'b1);
        for (n = 0; n < 200 && serial_out !== 1'b0; n++) @(posedge pclk);
        check(serial_out, 1'b0);
        do_reset();
        check({serial_out, tx_n}, 2'h3);
        $display("tx fill test done");
    endtask : t_txfill

    ////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ovr = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pins();
        t_alert();
        t_loop();
        t_flow();
        t_txfill();
        tally_and_finish();
    end
endmodule : uart_pin_channel_test
`default_nettype wire
